// File: rtl/ddr_consts.vh
// Constants of the dual DMA engine with receive ring management
`ifndef DDR_CONSTS_VH
`define DDR_CONSTS_VH

// Register offsets
`define DDR_REG_CTRL 4'h0
`define DDR_REG_RSTART 4'h1
`define DDR_REG_RSTOP 4'h2
`define DDR_REG_CURR 4'h3
`define DDR_REG_BNDRY 4'h4
`define DDR_REG_RADDR_LO 4'h5
`define DDR_REG_RADDR_HI 4'h6
`define DDR_REG_RCOUNT 4'h7
`define DDR_REG_TADDR 4'h8
`define DDR_REG_TCOUNT 4'h9
`define DDR_REG_STATUS 4'hA
`define DDR_REG_UPPER 4'hB

// Control fields
`define DDR_CTRL_RXEN 0
`define DDR_CTRL_RREAD 1
`define DDR_CTRL_RWRITE 2
`define DDR_CTRL_TXGO 3
`define DDR_CTRL_WIDE 4
`define DDR_CTRL_LONG 5

// Status fields
`define DDR_ST_ABORT 0
`define DDR_ST_RDONE 1
`define DDR_ST_TDONE 2
`define DDR_ST_TXFAIL 3
`define DDR_ST_RXOK 4

// Reset values
`define DDR_RST_CTRL 8'h00
`define DDR_RST_PAGE 8'h00
`define DDR_RST_UPPER 16'h0000

// Timing: four bus cycles per memory cycle, wait sampled in t3
`define DDR_T1 2'h0
`define DDR_T2 2'h1
`define DDR_T3 2'h2
`define DDR_T4 2'h3
`define DDR_MAX_COLL 4'hF
`define DDR_STATUS_BYTES 8'h04

`endif

// File: rtl/ddr_dma.v
// Dual DMA engine: local receive/transmit channel, remote channel, receive ring
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "ddr_consts.vh"

module ddr_dma #(
  parameter DW = 16
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Register port
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // Local memory bus
  output reg [31:0] mem_addr,
  output reg [DW-1:0] mem_wdata,
  input wire [DW-1:0] mem_rdata,
  output reg mem_rd,
  output reg mem_wr,
  output reg mem_wide,
  input wire mem_wait,
  // External latch
  output reg latch_load_strobe,
  input wire latch_read_ack,
  input wire latch_write_ack,
  output reg latch_output_enable,
  output reg [DW-1:0] latch_wdata,
  input wire [DW-1:0] latch_rdata,
  // Receive FIFO side
  input wire rx_valid,
  input wire [DW-1:0] rx_data,
  output wire rx_ready,
  input wire rx_end,
  input wire rx_good,
  input wire rx_reject,
  // Transmit FIFO side
  output reg tx_valid,
  output reg [DW-1:0] tx_data,
  input wire tx_ready,
  input wire tx_collision,
  input wire tx_ok
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [7:0] ctrl;
  reg [7:0] ring_start_page;
  reg [7:0] ring_stop_page;
  reg [7:0] curr_page;
  reg [7:0] bndry_page;
  reg [15:0] rem_addr;
  reg [7:0] rem_count;
  reg [7:0] tx_page;
  reg [7:0] tx_count;
  reg [15:0] upper_addr;
  reg [7:0] status;

  // ----------------------------------------
  // Working state
  // ----------------------------------------
  localparam S_IDLE = 2'h0;
  localparam S_CYC = 2'h1;
  reg [1:0] state;
  reg [1:0] phase;
  reg [1:0] owner;
  localparam O_RX = 2'h0;
  localparam O_TX = 2'h1;
  localparam O_RRD = 2'h2;
  localparam O_RWR = 2'h3;
  reg last_local;
  reg [15:0] rx_addr;
  reg [7:0] next_page_scratch;
  reg rx_active;
  reg rx_hdr;
  reg [7:0] rx_bytes;
  reg [15:0] tx_addr;
  reg [7:0] tx_left;
  reg tx_active;
  reg [3:0] coll_cnt;
  reg latch_full;
  reg rd_pending;
  reg [DW-1:0] rx_hold;

  wire [7:0] step = ctrl[`DDR_CTRL_WIDE] ? 8'h02 : 8'h01;
  wire [15:0] rx_next = rx_addr + {8'h00, step};
  wire want_rx = rx_active && rx_valid;
  wire want_tx = tx_active && tx_left != 8'h00 && !tx_valid;
  wire want_rrd = ctrl[`DDR_CTRL_RREAD] && rem_count != 8'h00 && !latch_full && rd_pending;
  wire want_rwr = ctrl[`DDR_CTRL_RWRITE] && rem_count != 8'h00 && latch_write_ack;
  wire want_local = want_rx || want_tx;
  wire want_remote = want_rrd || want_rwr;
  wire pick_local = want_local && (!want_remote || !last_local);

  assign rx_ready = state == S_CYC && owner == O_RX && phase == `DDR_T4 && !rx_hdr;

  function [31:0] full_addr;
    input [15:0] low;
    begin
      full_addr = ctrl[`DDR_CTRL_LONG] ? {upper_addr, low} : {16'h0000, low};
    end
  endfunction

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `DDR_REG_CTRL: reg_rdata <= ctrl;
        `DDR_REG_RSTART: reg_rdata <= ring_start_page;
        `DDR_REG_RSTOP: reg_rdata <= ring_stop_page;
        `DDR_REG_CURR: reg_rdata <= curr_page;
        `DDR_REG_BNDRY: reg_rdata <= bndry_page;
        `DDR_REG_RADDR_LO: reg_rdata <= rem_addr[7:0];
        `DDR_REG_RADDR_HI: reg_rdata <= rem_addr[15:8];
        `DDR_REG_RCOUNT: reg_rdata <= rem_count;
        `DDR_REG_TADDR: reg_rdata <= tx_page;
        `DDR_REG_TCOUNT: reg_rdata <= tx_count;
        `DDR_REG_STATUS: reg_rdata <= status;
        `DDR_REG_UPPER: reg_rdata <= upper_addr[15:8];
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ----------------------------------------
  // DMA engine
  // ----------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      ctrl <= `DDR_RST_CTRL;
      ring_start_page <= `DDR_RST_PAGE;
      ring_stop_page <= `DDR_RST_PAGE;
      curr_page <= `DDR_RST_PAGE;
      bndry_page <= `DDR_RST_PAGE;
      rem_addr <= 16'h0000;
      rem_count <= 8'h00;
      tx_page <= 8'h00;
      tx_count <= 8'h00;
      upper_addr <= `DDR_RST_UPPER;
      status <= 8'h00;
      state <= S_IDLE;
      phase <= `DDR_T1;
      owner <= O_RX;
      last_local <= 1'b0;
      rx_addr <= 16'h0000;
      next_page_scratch <= 8'h00;
      rx_active <= 1'b0;
      rx_hdr <= 1'b0;
      rx_bytes <= 8'h00;
      tx_addr <= 16'h0000;
      tx_left <= 8'h00;
      tx_active <= 1'b0;
      coll_cnt <= 4'h0;
      latch_full <= 1'b0;
      rd_pending <= 1'b0;
      rx_hold <= {DW{1'b0}};
      mem_addr <= 32'h00000000;
      mem_wdata <= {DW{1'b0}};
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      mem_wide <= 1'b0;
      latch_load_strobe <= 1'b0;
      latch_output_enable <= 1'b0;
      latch_wdata <= {DW{1'b0}};
      tx_valid <= 1'b0;
      tx_data <= {DW{1'b0}};
    end else begin
      if (tx_valid && tx_ready) begin
        tx_valid <= 1'b0;
      end
      if (latch_read_ack) begin
        latch_full <= 1'b0;
        rd_pending <= 1'b1;
      end
      if (reg_wr) begin
        case (reg_addr)
          `DDR_REG_CTRL: begin
            ctrl <= reg_wdata;
            if (reg_wdata[`DDR_CTRL_RREAD]) begin
              rd_pending <= 1'b1;
            end
            if (reg_wdata[`DDR_CTRL_TXGO]) begin
              tx_active <= 1'b1;
              tx_addr <= {tx_page, 8'h00};
              tx_left <= tx_count;
              coll_cnt <= 4'h0;
            end
            if (reg_wdata[`DDR_CTRL_RXEN] && !rx_active) begin
              rx_active <= 1'b1;
              rx_hdr <= 1'b0;
              rx_bytes <= 8'h00;
              rx_addr <= {curr_page, `DDR_STATUS_BYTES};
            end
          end
          `DDR_REG_RSTART: ring_start_page <= reg_wdata;
          `DDR_REG_RSTOP: ring_stop_page <= reg_wdata;
          `DDR_REG_CURR: curr_page <= reg_wdata;
          `DDR_REG_BNDRY: begin
            bndry_page <= reg_wdata;
            rem_addr <= {reg_wdata, 8'h00};
          end
          `DDR_REG_RADDR_LO: rem_addr[7:0] <= reg_wdata;
          `DDR_REG_RADDR_HI: rem_addr[15:8] <= reg_wdata;
          `DDR_REG_RCOUNT: rem_count <= reg_wdata;
          `DDR_REG_TADDR: tx_page <= reg_wdata;
          `DDR_REG_TCOUNT: tx_count <= reg_wdata;
          `DDR_REG_STATUS: status <= status & ~reg_wdata;
          `DDR_REG_UPPER: upper_addr <= {reg_wdata, reg_wdata};
          default: ;
        endcase
      end
      // Collision: rewind and resend without software, fail after the last try
      if (tx_collision && tx_active) begin
        if (coll_cnt == `DDR_MAX_COLL) begin
          tx_active <= 1'b0;
          status[`DDR_ST_TXFAIL] <= 1'b1;
        end else begin
          coll_cnt <= coll_cnt + 4'h1;
          tx_addr <= {tx_page, 8'h00};
          tx_left <= tx_count;
        end
      end else if (tx_ok && tx_active) begin
        tx_active <= 1'b0;
        status[`DDR_ST_TDONE] <= 1'b1;
      end
      // End of packet: status header at current page, or reclaim
      if (rx_end && rx_active && !rx_hdr) begin
        if (rx_good && !rx_reject) begin
          rx_hdr <= 1'b1;
          next_page_scratch <= (rx_addr[7:0] == 8'h00) ? rx_addr[15:8] :
            ((rx_addr[15:8] + 8'h01 == ring_stop_page) ? ring_start_page : rx_addr[15:8] + 8'h01);
          rx_hold <= {rx_bytes, 8'h01};
          rx_addr <= {curr_page, 8'h00};
        end else begin
          rx_addr <= {curr_page, `DDR_STATUS_BYTES};
          rx_bytes <= 8'h00;
        end
      end
      case (state)
        S_IDLE: begin
          if (rx_hdr || want_local || want_remote) begin
            state <= S_CYC;
            phase <= `DDR_T1;
            mem_wide <= ctrl[`DDR_CTRL_WIDE];
            if (rx_hdr) begin
              owner <= O_RX;
              mem_addr <= full_addr(rx_addr);
              mem_wdata <= rx_hold;
              mem_wr <= 1'b1;
            end else if (pick_local) begin
              last_local <= 1'b1;
              owner <= want_rx ? O_RX : O_TX;
              mem_addr <= full_addr(want_rx ? rx_addr : tx_addr);
              mem_wdata <= rx_data;
              mem_wr <= want_rx;
              mem_rd <= !want_rx;
            end else begin
              last_local <= 1'b0;
              owner <= want_rwr ? O_RWR : O_RRD;
              mem_addr <= full_addr(rem_addr);
              mem_wr <= want_rwr;
              mem_rd <= !want_rwr;
              latch_output_enable <= want_rwr;
              rd_pending <= 1'b0;
            end
          end
        end
        S_CYC: begin
          // Wait sampled only in t3, each wait adds one whole clock
          if (!(phase == `DDR_T3 && mem_wait)) begin
            phase <= phase + 2'h1;
          end
          if (phase == `DDR_T3 && !mem_wait) begin
            if (owner == O_RRD) begin
              latch_wdata <= mem_rdata;
              latch_load_strobe <= 1'b1;
            end
            if (owner == O_RWR) begin
              mem_wdata <= latch_rdata;
            end
            if (owner == O_TX) begin
              tx_data <= mem_rdata;
            end
          end
          if (phase == `DDR_T4) begin
            state <= S_IDLE;
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            latch_load_strobe <= 1'b0;
            latch_output_enable <= 1'b0;
            case (owner)
              O_RX: begin
                if (rx_hdr) begin
                  rx_hdr <= 1'b0;
                  curr_page <= next_page_scratch;
                  rx_addr <= {next_page_scratch, `DDR_STATUS_BYTES};
                  rx_bytes <= 8'h00;
                  status[`DDR_ST_RXOK] <= 1'b1;
                end else begin
                  rx_bytes <= rx_bytes + step;
                  if (rx_next[7:0] == 8'h00) begin
                    // Linking: stop page checked before boundary
                    if (rx_next[15:8] == ring_stop_page) begin
                      rx_addr <= {ring_start_page, 8'h00};
                      if (ring_start_page == bndry_page) begin
                        rx_active <= 1'b0;
                        status[`DDR_ST_ABORT] <= 1'b1;
                      end
                    end else if (rx_next[15:8] == bndry_page) begin
                      rx_active <= 1'b0;
                      status[`DDR_ST_ABORT] <= 1'b1;
                    end else begin
                      rx_addr <= rx_next;
                    end
                  end else begin
                    rx_addr <= rx_next;
                  end
                end
              end
              O_TX: begin
                tx_valid <= 1'b1;
                // A collision in this same clock must still rewind the packet
                tx_addr <= tx_collision ? {tx_page, 8'h00} : tx_addr + {8'h00, step};
                tx_left <= tx_collision ? tx_count : ((tx_left > step) ? tx_left - step : 8'h00);
              end
              default: begin
                rem_addr <= rem_addr + {8'h00, step};
                rem_count <= (rem_count > step) ? rem_count - step : 8'h00;
                if (owner == O_RRD) begin
                  latch_full <= 1'b1;
                end
                if (rem_count <= step) begin
                  status[`DDR_ST_RDONE] <= 1'b1;
                end
              end
            endcase
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

endmodule

// File: sim/ddr_dma_sva.sv
// Concurrent checks on the memory cycle and latch handshake of the DMA engine
`timescale 1ns/1ps
module ddr_dma_sva (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Memory bus
  input wire [31:0] mem_addr,
  input wire mem_rd,
  input wire mem_wr,
  input wire mem_wide,
  input wire mem_wait,
  // Latch and FIFO
  input wire latch_load_strobe,
  input wire latch_output_enable,
  input wire rx_ready
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  wire strobe;
  assign strobe = mem_rd || mem_wr;
  // ----------------------------------------
  // Cycle shape
  // ----------------------------------------
  cycle_len_a: assert property (($rose(strobe) ##2 !mem_wait) |-> ##1 strobe ##1 !strobe)
    else $error("memory cycle is not four clocks");
  wait_stretch_a: assert property (($rose(strobe) ##2 mem_wait ##1 !mem_wait) |-> ##1 strobe ##1 !strobe)
    else $error("wait did not add exactly one clock");
  addr_hold_a: assert property ((strobe && $past(strobe)) |-> $stable(mem_addr) && $stable(mem_rd))
    else $error("address or direction moved inside a cycle");
  word_width_a: assert property ((strobe && $past(strobe)) |-> $stable(mem_wide))
    else $error("transfer width moved inside a cycle");
  rdwr_excl_a: assert property (!(mem_rd && mem_wr))
    else $error("read and write cycles overlap");
  // ----------------------------------------
  // Latch and FIFO handshakes
  // ----------------------------------------
  load_pulse_a: assert property (latch_load_strobe |-> mem_rd ##1 !latch_load_strobe)
    else $error("latch load outside a one-clock read slot");
  oe_write_a: assert property (latch_output_enable |-> mem_wr && !latch_load_strobe)
    else $error("latch enabled outside a write cycle");
  rx_ready_a: assert property (rx_ready |-> mem_wr && !latch_output_enable && $past(strobe, 3))
    else $error("fifo word taken outside a local write");
  cover property ($rose(strobe) ##2 mem_wait);
  cover property (latch_load_strobe);
  cover property (latch_output_enable);
  cover property (rx_ready);
endmodule

bind ddr_dma ddr_dma_sva u_ddr_dma_sva (.clk(clk), .sys_rst(sys_rst), .mem_addr(mem_addr), .mem_rd(mem_rd),
  .mem_wr(mem_wr), .mem_wide(mem_wide), .mem_wait(mem_wait), .latch_load_strobe(latch_load_strobe),
  .latch_output_enable(latch_output_enable), .rx_ready(rx_ready));

// File: sim/ddr_mem_model.sv
// Buffer memory, wait logic and host side of the external latch
`timescale 1ns/1ps
module ddr_mem_model (
  // Clock and mode
  input wire clk,
  input wire slow,
  input wire wr_go,
  // Local memory
  input wire [31:0] mem_addr,
  input wire [15:0] mem_wdata,
  output wire [15:0] mem_rdata,
  input wire mem_rd,
  input wire mem_wr,
  output wire mem_wait,
  // Latch
  input wire latch_load_strobe,
  input wire [15:0] latch_wdata,
  output reg latch_read_ack,
  output wire latch_write_ack,
  input wire latch_output_enable,
  output wire [15:0] latch_rdata
);
  logic [15:0] mem [0:1023];
  logic [15:0] got [$];
  logic [2:0] ph = 3'h0;
  logic [1:0] dly = 2'h0;
  logic [15:0] widx = 16'h0000;
  logic [15:0] noise = 16'h0000;
  logic oe_d = 1'b0;
  initial begin
    latch_read_ack = 1'b0;
    for (int i = 0; i < 1024; i++) mem[i] = {~i[7:0], i[7:0]};
  end
  // Undriven bus shows a moving pattern, not the last word
  assign mem_rdata = mem_rd ? mem[mem_addr[10:1]] : noise;
  assign mem_wait = slow && (mem_rd || mem_wr) && ph == 3'h2;
  assign latch_write_ack = wr_go;
  assign latch_rdata = wr_go ? 16'h3C00 + widx : ~noise;
  always @(posedge clk) begin
    noise <= noise + 16'h1111;
    ph <= (mem_rd || mem_wr) ? ph + 3'h1 : 3'h0;
    if (mem_wr) mem[mem_addr[10:1]] <= mem_wdata;
    oe_d <= latch_output_enable;
    if (oe_d && !latch_output_enable) widx <= widx + 16'h0001;
    latch_read_ack <= (dly == 2'h1);
    if (latch_load_strobe) begin
      got.push_back(latch_wdata);
      dly <= slow ? 2'h3 : 2'h1;
    end else if (dly != 2'h0) begin
      dly <= dly - 2'h1;
    end
  end
endmodule

// File: sim/ddr_dma_test.sv
// Self-checking bench for the DMA engine and receive ring
`timescale 1ns/1ps
`include "ddr_consts.vh"
module ddr_dma_test;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rx_valid = 1'b0;
  logic rx_end = 1'b0;
  logic rx_good = 1'b0;
  logic slow = 1'b0;
  logic wr_go = 1'b0;
  logic [15:0] rx_data = 16'h0000;
  logic tx_collision = 1'b0;
  logic tx_ok = 1'b0;
  wire tx_valid, mem_wide;
  wire [15:0] tx_data;
  logic [15:0] txq [$];
  logic [15:0] hi_seen = 16'h0000;
  logic [7:0] d;
  wire [7:0] reg_rdata;
  wire [31:0] mem_addr;
  wire [15:0] mem_wdata, mem_rdata, latch_wdata, latch_rdata;
  wire mem_rd, mem_wr, mem_wait, latch_load_strobe, latch_read_ack, latch_write_ack, latch_output_enable;
  wire rx_ready;
  int bad_count = 0;
  int checks = 0;

  ddr_dma #(.DW(16)) u_ddr_dma (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wide(mem_wide), .mem_wait(mem_wait),
    .latch_load_strobe(latch_load_strobe), .latch_read_ack(latch_read_ack), .latch_write_ack(latch_write_ack),
    .latch_output_enable(latch_output_enable), .latch_wdata(latch_wdata), .latch_rdata(latch_rdata),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready), .rx_end(rx_end), .rx_good(rx_good),
    .rx_reject(1'b0), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(1'b1), .tx_collision(tx_collision),
    .tx_ok(tx_ok));

  ddr_mem_model u_ddr_mem_model (.clk(clk), .slow(slow), .wr_go(wr_go), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wait(mem_wait),
    .latch_load_strobe(latch_load_strobe), .latch_wdata(latch_wdata), .latch_read_ack(latch_read_ack),
    .latch_write_ack(latch_write_ack), .latch_output_enable(latch_output_enable), .latch_rdata(latch_rdata));

  // Transmit words and upper address as the far side sees them
  always @(posedge clk) begin
    if (tx_valid) txq.push_back(tx_data);
    if (mem_rd) hi_seen <= mem_addr[31:16];
  end

  // ----------------------------------------
  // Bench tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Polls a status bit, then clears it so later waits see fresh events
  task automatic wait_st(input int b);
    d = 8'h00;
    for (int i = 0; i < 300 && d[b] !== 1'b1; i++) rd(`DDR_REG_STATUS);
    chk(d[b], 1'b1);
    wr(`DDR_REG_STATUS, 8'h01 << b);
  endtask
  // Words are offered until taken; a stalled ring ends the packet early
  task automatic rx_pkt(input int n, input logic [15:0] base);
    int t;
    @(posedge clk);
    for (int k = 0; k < n; k++) begin
      rx_valid <= 1'b1;
      rx_data <= base + k[15:0];
      t = 0;
      do @(negedge clk); while (rx_ready !== 1'b1 && ++t < 40);
      @(posedge clk);
      if (t >= 40) break;
    end
    rx_valid <= 1'b0;
    rx_end <= 1'b1;
    rx_good <= 1'b1;
    @(posedge clk);
    rx_end <= 1'b0;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------
  initial begin
    forever #2 clk = ~clk;
  end
  initial begin
    #100000;
    bad_count++;
    tally_and_finish;
  end
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    for (int a = 0; a < 13; a++) begin
      rd(a[3:0]);
      chk(d, 8'h00);
    end
    wr(4'hC, 8'h5A);
    rd(4'hC);
    chk(d, 8'h00);
    // Remote read from the boundary page with slow host and waits
    slow <= 1'b1;
    wr(`DDR_REG_BNDRY, 8'h41);
    wr(`DDR_REG_RCOUNT, 8'h04);
    wr(`DDR_REG_CTRL, 8'h12);
    wait_st(`DDR_ST_RDONE);
    chk(16'(u_ddr_mem_model.got.size()), 16'h0002);
    chk(u_ddr_mem_model.got[0], 16'h7F80);
    chk(u_ddr_mem_model.got[1], 16'h7E81);
    // Remote read off first, or the last refill would run on the new count
    wr(`DDR_REG_CTRL, 8'h10);
    // Remote write into page 43
    wr(`DDR_REG_RADDR_LO, 8'h00);
    wr(`DDR_REG_RADDR_HI, 8'h43);
    wr(`DDR_REG_RCOUNT, 8'h04);
    wr_go <= 1'b1;
    wr(`DDR_REG_CTRL, 8'h14);
    wait_st(`DDR_ST_RDONE);
    wr_go <= 1'b0;
    chk(u_ddr_mem_model.mem[10'h180], 16'h3C00);
    chk(u_ddr_mem_model.mem[10'h181], 16'h3C01);
    // Ring of pages 40..41, pointers seeded from the start page
    slow <= 1'b0;
    wr(`DDR_REG_RSTART, 8'h40);
    wr(`DDR_REG_RSTOP, 8'h42);
    wr(`DDR_REG_CURR, 8'h40);
    wr(`DDR_REG_BNDRY, 8'h40);
    wr(`DDR_REG_CTRL, 8'h11);
    rx_pkt(4, 16'hB000);
    wait_st(`DDR_ST_RXOK);
    for (int k = 0; k < 4; k++) chk(u_ddr_mem_model.mem[10'h002 + k], 16'hB000 + k[15:0]);
    chk(u_ddr_mem_model.mem[10'h000], 16'h0801);
    rd(`DDR_REG_CURR);
    chk(d, 8'h41);
    // Long packet wraps at the stop page onto the boundary and aborts
    rx_pkt(200, 16'hC000);
    wait_st(`DDR_ST_ABORT);
    rd(`DDR_REG_CURR);
    chk(d, 8'h41);
    chk(u_ddr_mem_model.mem[10'h082], 16'hC000);
    chk(u_ddr_mem_model.mem[10'h100], 16'hFF00);
    chk(u_ddr_mem_model.mem[10'h002], 16'hB000);
    // Transmit page 43 in long mode, one collision resends it
    wr(`DDR_REG_UPPER, 8'h12);
    wr(`DDR_REG_TADDR, 8'h43);
    wr(`DDR_REG_TCOUNT, 8'h04);
    wr(`DDR_REG_CTRL, 8'h38);
    repeat (20) @(posedge clk);
    tx_collision <= 1'b1;
    @(posedge clk);
    tx_collision <= 1'b0;
    repeat (20) @(posedge clk);
    tx_ok <= 1'b1;
    @(posedge clk);
    tx_ok <= 1'b0;
    wait_st(`DDR_ST_TDONE);
    chk(16'(txq.size()), 16'h0004);
    for (int k = 0; k < 4; k++) chk(txq[k], 16'h3C00 + {15'h0000, k[0]});
    chk(hi_seen, 16'h1212);
    chk(mem_wide, 1'b1);
    // Fifteen collisions are retried, the sixteenth gives up
    wr(`DDR_REG_CTRL, 8'h18);
    for (int k = 0; k < 16; k++) begin
      if (k == 15) begin
        rd(`DDR_REG_STATUS);
        chk(d[`DDR_ST_TXFAIL], 1'b0);
      end
      repeat (20) @(posedge clk);
      tx_collision <= 1'b1;
      @(posedge clk);
      tx_collision <= 1'b0;
    end
    wait_st(`DDR_ST_TXFAIL);
    tally_and_finish;
  end
endmodule
